// ===== src/ougcb_pkg.sv
// constants of the octal uart global configuration bank
// assumes an 8-bit host address space and eight channel windows
`default_nettype none

package ougcb_pkg;

  typedef logic [7:0] ougcb_byte_t;
  typedef logic [3:0] ougcb_nib_t;

  // geometry of the address space
  localparam int          NUM_CHAN        = 8;
  localparam int          CODE_W          = 3;
  localparam int          ADDR_GLOBAL_BIT = 7;
  localparam int          CHAN_SEL_LSB    = 4;
  localparam int          LEGACY_REGS     = 8;

  // global register offsets
  localparam ougcb_byte_t OFS_PENDING     = 8'h80;
  localparam ougcb_byte_t OFS_CODE_LOW    = 8'h81;
  localparam ougcb_byte_t OFS_CODE_MID    = 8'h82;
  localparam ougcb_byte_t OFS_CODE_HIGH   = 8'h83;
  localparam ougcb_byte_t OFS_TIMER_CTRL  = 8'h84;
  localparam ougcb_byte_t OFS_TIMER_RSVD  = 8'h85;
  localparam ougcb_byte_t OFS_TCOUNT_LOW  = 8'h86;
  localparam ougcb_byte_t OFS_TCOUNT_HIGH = 8'h87;
  localparam ougcb_byte_t OFS_SAMPLE_8X   = 8'h88;
  localparam ougcb_byte_t OFS_RSVD_ONE    = 8'h89;
  localparam ougcb_byte_t OFS_SOFT_RESET  = 8'h8A;
  localparam ougcb_byte_t OFS_SLEEP       = 8'h8B;
  localparam ougcb_byte_t OFS_REVISION    = 8'h8C;
  localparam ougcb_byte_t OFS_DEVICE_ID   = 8'h8D;
  localparam ougcb_byte_t OFS_BCAST       = 8'h8E;

  // field positions
  localparam int          TCTRL_IRQ_EN    = 0;
  localparam int          TCTRL_START     = 1;
  localparam int          TCTRL_ONESHOT   = 2;
  localparam int          TCTRL_EXT_CLK   = 3;
  localparam int          BCAST_BIT       = 0;

  // reset values
  localparam ougcb_byte_t RST_BYTE        = 8'h00;
  localparam ougcb_nib_t  RST_TCTRL       = 4'h0;

  // interrupt source codes
  localparam logic [2:0]  CODE_NONE       = 3'h0;
  localparam logic [2:0]  CODE_RX         = 3'h1;
  localparam logic [2:0]  CODE_RX_TMO     = 3'h2;
  localparam logic [2:0]  CODE_TX_EMPTY   = 3'h3;
  localparam logic [2:0]  CODE_MODEM      = 3'h4;
  localparam logic [2:0]  CODE_TIMER      = 3'h7;

  // timing counts
  localparam int          SRST_HOLD_CYCLES = 4;
  localparam int          SRST_CNT_W       = 3;

endpackage : ougcb_pkg

`default_nettype wire

// ===== src/ougcb_sync.sv
// two flip-flop synchroniser for a group of pin levels
// assumes the inputs are levels from outside the clk domain
`default_nettype none

module ougcb_sync #(
  parameter int              WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;

  ////////////////////////////////////////////////////////////////////////////
  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      meta_ff  <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      meta_ff  <= pin_in;
      sync_out <= meta_ff;
    end
  end

endmodule : ougcb_sync

`default_nettype wire

// ===== src/ougcb_sticky.sv
// sticky event flag, set wins over a clear in the same cycle
// assumes set and clear are single-cycle pulses on clk
`default_nettype none

module ougcb_sticky (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic set_pulse,
  input  wire logic clr_pulse,
  output logic      flag_ff
);

  logic nxt_flag;

  ////////////////////////////////////////////////////////////////////////////
  // next value: an event in the clearing cycle is kept
  assign nxt_flag = set_pulse | (flag_ff & ~clr_pulse);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      flag_ff <= 1'b0;
    end
    else
    begin
      flag_ff <= nxt_flag;
    end
  end

endmodule : ougcb_sticky

`default_nettype wire

// ===== src/ougcb_global_bank.sv
// global configuration and status bank of an octal uart
// assumes channel logic on clk supplies irq requests, codes and read data;
// host bus pins are asynchronous and are synchronised here
`default_nettype none

module ougcb_global_bank #(
  parameter ougcb_pkg::ougcb_byte_t REVISION_CODE = 8'hA5, // arbitrary value
  parameter ougcb_pkg::ougcb_byte_t DEVICE_IDENT  = 8'h5A, // arbitrary value
  parameter int SRST_HOLD = ougcb_pkg::SRST_HOLD_CYCLES
) (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   host_cs_n,
  input  wire logic                   host_rd_n,
  input  wire logic                   host_wr_n,
  input  wire ougcb_pkg::ougcb_byte_t host_addr,
  input  wire ougcb_pkg::ougcb_byte_t host_data_in,
  output ougcb_pkg::ougcb_byte_t      host_data_out,
  output logic                        host_data_oe_n,
  output logic                        irq,
  input  wire logic [7:0]             chan_irq_req,
  input  wire logic [23:0]            chan_irq_code,
  input  wire logic [63:0]            chan_rdata,
  input  wire logic                   timer_timeout,
  input  wire logic                   wake_event,
  output logic [7:0]                  chan_sel,
  output logic                        chan_rd_pulse,
  output logic                        chan_wr_pulse,
  output logic [3:0]                  chan_reg_addr,
  output ougcb_pkg::ougcb_byte_t      chan_wdata,
  output ougcb_pkg::ougcb_byte_t      sampling_8x,
  output ougcb_pkg::ougcb_byte_t      sleep_en,
  output ougcb_pkg::ougcb_byte_t      chan_soft_reset,
  output ougcb_pkg::ougcb_nib_t       timer_ctrl,
  output logic [15:0]                 timer_count
);
  import ougcb_pkg::*;

  // equality of the synchronised address with a global offset
  function automatic logic hit(input ougcb_byte_t a, input ougcb_byte_t o);
    hit = (a == o);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation
  logic [2:0]  strb_s;
  ougcb_byte_t addr_s;
  ougcb_byte_t wdat_s;

  ougcb_sync #(.WIDTH(3), .RESET_VAL(3'h7)) u_strb_sync (
    .clk      (clk),
    .reset    (reset),
    .pin_in   ({host_cs_n, host_rd_n, host_wr_n}),
    .sync_out (strb_s)
  );

  ougcb_sync #(.WIDTH(16), .RESET_VAL(16'h0000)) u_bus_sync (
    .clk      (clk),
    .reset    (reset),
    .pin_in   ({host_addr, host_data_in}),
    .sync_out ({addr_s, wdat_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // strobe edges: read acts at its start, write at its end
  logic rd_act;
  logic wr_act;
  logic rd_act_ff;
  logic wr_act_ff;
  logic rd_start;
  logic wr_end;
  ougcb_byte_t wr_addr_ff;
  ougcb_byte_t wr_data_ff;

  assign rd_act   = ~strb_s[2] & ~strb_s[1];
  assign wr_act   = ~strb_s[2] & ~strb_s[0];
  assign rd_start = rd_act & ~rd_act_ff;
  assign wr_end   = wr_act_ff & ~wr_act;

  // address and data held from the last cycle of the write strobe
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rd_act_ff  <= 1'b0;
      wr_act_ff  <= 1'b0;
      wr_addr_ff <= RST_BYTE;
      wr_data_ff <= RST_BYTE;
    end
    else
    begin
      rd_act_ff  <= rd_act;
      wr_act_ff  <= wr_act;
      if (wr_act)
      begin
        wr_addr_ff <= addr_s;
        wr_data_ff <= wdat_s;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address decode of the 256-byte space
  logic rd_global;
  logic wr_global;
  logic rd_chan;
  logic wr_chan;
  logic [2:0] rd_chan_idx;
  logic [2:0] wr_chan_idx;

  assign rd_global   = rd_start & addr_s[ADDR_GLOBAL_BIT];
  assign wr_global   = wr_end & wr_addr_ff[ADDR_GLOBAL_BIT];
  assign rd_chan     = rd_start & ~addr_s[ADDR_GLOBAL_BIT];
  assign wr_chan     = wr_end & ~wr_addr_ff[ADDR_GLOBAL_BIT];
  assign rd_chan_idx = addr_s[6:CHAN_SEL_LSB];
  assign wr_chan_idx = wr_addr_ff[6:CHAN_SEL_LSB];

  // global write and read strobes
  logic wr_tctrl;
  logic wr_tlow;
  logic wr_thigh;
  logic wr_sample;
  logic wr_srst;
  logic wr_sleep;
  logic wr_bcast;
  logic rd_pending;
  logic rd_tctrl;

  assign wr_tctrl   = wr_global & hit(wr_addr_ff, OFS_TIMER_CTRL);
  assign wr_tlow    = wr_global & hit(wr_addr_ff, OFS_TCOUNT_LOW);
  assign wr_thigh   = wr_global & hit(wr_addr_ff, OFS_TCOUNT_HIGH);
  assign wr_sample  = wr_global & hit(wr_addr_ff, OFS_SAMPLE_8X);
  assign wr_srst    = wr_global & hit(wr_addr_ff, OFS_SOFT_RESET);
  assign wr_sleep   = wr_global & hit(wr_addr_ff, OFS_SLEEP);
  assign wr_bcast   = wr_global & hit(wr_addr_ff, OFS_BCAST);
  assign rd_pending = rd_global & hit(addr_s, OFS_PENDING);
  assign rd_tctrl   = rd_global & hit(addr_s, OFS_TIMER_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  ougcb_nib_t  tctrl_ff;
  ougcb_byte_t tlow_ff;
  ougcb_byte_t thigh_ff;
  ougcb_byte_t sample_ff;
  ougcb_byte_t sleep_ff;
  logic        bcast_ff;

  // zero after hardware reset, reserved offsets have no writer
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      tctrl_ff  <= RST_TCTRL;
      tlow_ff   <= RST_BYTE;
      thigh_ff  <= RST_BYTE;
      sample_ff <= RST_BYTE;
      sleep_ff  <= RST_BYTE;
      bcast_ff  <= 1'b0;
    end
    else
    begin
      if (wr_tctrl)
        tctrl_ff <= wr_data_ff[3:0];
      if (wr_tlow)
        tlow_ff <= wr_data_ff;
      if (wr_thigh)
        thigh_ff <= wr_data_ff;
      if (wr_sample)
        sample_ff <= wr_data_ff;
      if (wr_sleep)
        sleep_ff <= wr_data_ff;
      if (wr_bcast)
        bcast_ff <= wr_data_ff[BCAST_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // soft reset: a bit holds SRST_HOLD cycles then clears itself
  ougcb_byte_t srst_ff;
  logic [SRST_CNT_W-1:0] srst_cnt_ff [NUM_CHAN];
  localparam logic [SRST_CNT_W-1:0] SRST_LAST = SRST_CNT_W'(SRST_HOLD - 1);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      srst_ff <= RST_BYTE;
      for (int i = 0; i < NUM_CHAN; i++)
        srst_cnt_ff[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_CHAN; i++)
      begin
        if (srst_ff[i])
        begin
          srst_cnt_ff[i] <= srst_cnt_ff[i] + 1'b1;
          if (srst_cnt_ff[i] == SRST_LAST)
            srst_ff[i] <= 1'b0;
        end
        else if (wr_srst && wr_data_ff[i])
        begin
          srst_ff[i]     <= 1'b1;
          srst_cnt_ff[i] <= '0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer and wake sticky flags
  logic timer_flag;
  logic wake_flag;
  logic timer_set;
  logic wake_set;

  assign timer_set = timer_timeout & tctrl_ff[TCTRL_IRQ_EN];
  assign wake_set  = wake_event & (&sleep_ff);

  ougcb_sticky u_timer_flag (
    .clk       (clk),
    .reset     (reset),
    .set_pulse (timer_set),
    .clr_pulse (rd_tctrl),
    .flag_ff   (timer_flag)
  );

  ougcb_sticky u_wake_flag (
    .clk       (clk),
    .reset     (reset),
    .set_pulse (wake_set),
    .clr_pulse (rd_pending),
    .flag_ff   (wake_flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // global interrupt status, follows the channel requests directly
  ougcb_byte_t pend_ff;
  logic [23:0] code_ff;
  ougcb_byte_t nxt_pend;
  logic [23:0] nxt_code;
  logic [2:0]  ch0_code;

  // timer code is lowest priority, shown only on channel 0
  assign ch0_code = (chan_irq_code[2:0] != CODE_NONE) ? chan_irq_code[2:0] :
                    (timer_flag ? CODE_TIMER : CODE_NONE);
  assign nxt_pend = chan_irq_req | {7'h00, timer_flag};
  assign nxt_code = {chan_irq_code[23:3], ch0_code};

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pend_ff <= RST_BYTE;
      code_ff <= 24'h000000;
      irq     <= 1'b0;
    end
    else
    begin
      pend_ff <= nxt_pend;
      code_ff <= nxt_code;
      irq     <= (|nxt_pend) | wake_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data selection
  ougcb_byte_t glob_rdata;
  ougcb_byte_t chan_byte;
  ougcb_byte_t nxt_rdata;

  assign chan_byte = chan_rdata[rd_chan_idx*8 +: 8];
  assign glob_rdata =
    hit(addr_s, OFS_PENDING)     ? pend_ff          :
    hit(addr_s, OFS_CODE_LOW)    ? code_ff[7:0]     :
    hit(addr_s, OFS_CODE_MID)    ? code_ff[15:8]    :
    hit(addr_s, OFS_CODE_HIGH)   ? code_ff[23:16]   :
    hit(addr_s, OFS_TIMER_CTRL)  ? {4'h0, tctrl_ff} :
    hit(addr_s, OFS_TCOUNT_LOW)  ? tlow_ff          :
    hit(addr_s, OFS_TCOUNT_HIGH) ? thigh_ff         :
    hit(addr_s, OFS_SAMPLE_8X)   ? sample_ff        :
    hit(addr_s, OFS_SLEEP)       ? sleep_ff         :
    hit(addr_s, OFS_REVISION)    ? REVISION_CODE    :
    hit(addr_s, OFS_DEVICE_ID)   ? DEVICE_IDENT     :
    hit(addr_s, OFS_BCAST)       ? {7'h00, bcast_ff} :
    RST_BYTE;
  assign nxt_rdata = addr_s[ADDR_GLOBAL_BIT] ? glob_rdata : chan_byte;

  // data is captured at the read start and held for the strobe
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      host_data_out  <= RST_BYTE;
      host_data_oe_n <= 1'b1;
    end
    else
    begin
      if (rd_start)
        host_data_out <= nxt_rdata;
      host_data_oe_n <= ~rd_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel window access, broadcast writes reach all channels
  ougcb_byte_t nxt_sel;

  assign nxt_sel = wr_chan ? (bcast_ff ? 8'hFF :
                              8'(1 << wr_chan_idx)) :
                   rd_chan ? 8'(1 << rd_chan_idx) : 8'h00;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      chan_sel      <= RST_BYTE;
      chan_rd_pulse <= 1'b0;
      chan_wr_pulse <= 1'b0;
      chan_reg_addr <= 4'h0;
      chan_wdata    <= RST_BYTE;
    end
    else
    begin
      chan_sel      <= nxt_sel;
      chan_rd_pulse <= rd_chan;
      chan_wr_pulse <= wr_chan;
      chan_reg_addr <= wr_chan ? wr_addr_ff[3:0] : addr_s[3:0];
      chan_wdata    <= wr_data_ff;
    end
  end

  // outputs to the channel and timer logic
  assign sampling_8x     = sample_ff;
  assign sleep_en        = sleep_ff;
  assign chan_soft_reset = srst_ff;
  assign timer_ctrl      = tctrl_ff;
  assign timer_count     = {thigh_ff, tlow_ff};

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence srst_hold_s;
    srst_ff[0] [*4] ##1 !srst_ff[0];
  endsequence

  AST_PEND_CLEAR: assert property (@(posedge clk) disable iff (reset)
    (chan_irq_req == 8'h00 && !timer_flag) |=> pend_ff == 8'h00)
    else $error("pending bits set without any request");

  AST_PEND_FOLLOW: assert property (@(posedge clk) disable iff (reset)
    $fell(chan_irq_req[3]) |=> !pend_ff[3])
    else $error("pending bit outlived its channel request");

  AST_CODE_CH5: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> code_ff[17:15] == $past(chan_irq_code[17:15]))
    else $error("channel 5 code not placed at bits 17 to 15");

  AST_TIMER_CODE: assert property (@(posedge clk) disable iff (reset)
    (chan_irq_code[2:0] == CODE_NONE && timer_flag)
      |=> code_ff[2:0] == CODE_TIMER && pend_ff[0])
    else $error("timer code missing on channel 0");

  AST_BCAST: assert property (@(posedge clk) disable iff (reset)
    (wr_chan && bcast_ff) |=> chan_sel == 8'hFF && chan_wr_pulse)
    else $error("broadcast write did not select all channels");

  AST_ONE_CHAN: assert property (@(posedge clk) disable iff (reset)
    (wr_chan && !bcast_ff) |=> $onehot(chan_sel)
      && chan_sel[$past(wr_chan_idx)])
    else $error("channel write selected the wrong window");

  AST_SRST_SELF_CLEAR: assert property (@(posedge clk) disable iff (reset)
    $rose(srst_ff[0]) |-> srst_hold_s)
    else $error("soft reset bit did not clear after its hold");

  AST_TCTRL_READ_CLEAR: assert property (@(posedge clk) disable iff (reset)
    (rd_tctrl && !timer_set) |=> !timer_flag ##1 !pend_ff[0]
      || $past(chan_irq_req[0]))
    else $error("timer control read did not clear the timer flag");

  AST_TCTRL_HI_ZERO: assert property (@(posedge clk) disable iff (reset)
    rd_tctrl |=> host_data_out[7:4] == 4'h0)
    else $error("timer control upper nibble not zero");

  AST_RSVD_WRITE: assert property (@(posedge clk) disable iff (reset)
    (wr_global && hit(wr_addr_ff, OFS_RSVD_ONE))
      |=> $stable(sample_ff) && $stable(sleep_ff) && $stable(tctrl_ff))
    else $error("reserved write changed a register");

  AST_WAKE: assert property (@(posedge clk) disable iff (reset)
    (wake_event && sleep_ff == 8'hFF) |=> ##1 irq)
    else $error("wake from full sleep raised no interrupt");

endmodule : ougcb_global_bank

`default_nettype wire

// ===== bench/ougcb_host.sv
// host processor model driving the asynchronous register bus
// assumes clk is the device clock; strobes are timed in its cycles
`default_nettype none

module ougcb_host (
  input  wire logic                   clk,
  output var  logic                   cs_n,
  output var  logic                   rd_n,
  output var  logic                   wr_n,
  output var  ougcb_pkg::ougcb_byte_t addr,
  output var  ougcb_pkg::ougcb_byte_t wdata,
  input  wire ougcb_pkg::ougcb_byte_t rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import ougcb_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // idle bus at time zero
  initial
  begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
  end

  // write cycle: 4 cycles low, 4 high; released lines show the inverse
  task automatic wr(input ougcb_byte_t a, input ougcb_byte_t d);
    @(negedge clk);
    addr = a;
    wdata = d;
    cs_n = 1'b0;
    wr_n = 1'b0;
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    wr_n = 1'b1;
    repeat (4) @(negedge clk);
    addr = ~a;
    wdata = ~d;
  endtask : wr

  // read cycle: data taken well after the 3-edge answer
  task automatic rd(input ougcb_byte_t a, output ougcb_byte_t d);
    @(negedge clk);
    addr = a;
    cs_n = 1'b0;
    rd_n = 1'b0;
    repeat (5) @(negedge clk);
    d = rdata;
    cs_n = 1'b1;
    rd_n = 1'b1;
    repeat (4) @(negedge clk);
    addr = ~a;
  endtask : rd

endmodule : ougcb_host

`default_nettype wire

// ===== bench/testbench.sv
// self-checking bench of the global configuration bank
// assumes the host model and the bank share clk; channel read data is static, requests and codes are set by the main sequence
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ougcb_pkg::*;

  localparam ougcb_byte_t REV = 8'hA5; // arbitrary value
  localparam ougcb_byte_t DID = 8'h5A; // arbitrary value
  logic        clk, reset, cs_n, rd_n, wr_n, oe_n, irq, rdp, wrp;
  logic        tmo, wake;
  ougcb_byte_t addr, din, dout, wd, s8x, slp, srst, sel, rv;
  logic [7:0]  req;
  logic [23:0] code;
  logic [63:0] crd;
  logic [3:0]  raddr;
  ougcb_nib_t  tctl;
  logic [15:0] tcnt;
  logic [7:0]  w_sel, w_data, srst_seen;
  logic [3:0]  w_addr;
  logic [11:0] r_seen;
  int          fails, n_compared;
  ougcb_byte_t wa[8] = '{8'h84, 8'h85, 8'h86, 8'h87,
                         8'h88, 8'h89, 8'h8B, 8'h8E};
  ougcb_byte_t wv[8] = '{8'hFF, 8'hFF, 8'h34, 8'h12,
                         8'h03, 8'hFF, 8'hA5, 8'h01};
  ougcb_byte_t we[8] = '{8'h0F, 8'h00, 8'h34, 8'h12,
                         8'h03, 8'h00, 8'hA5, 8'h01};

  ////////////////////////////////////////////////////////////////////
  ougcb_global_bank #(.REVISION_CODE(REV), .DEVICE_IDENT(DID))
    ougcb_global_bank_inst (
    .clk(clk), .reset(reset), .host_cs_n(cs_n), .host_rd_n(rd_n),
    .host_wr_n(wr_n), .host_addr(addr), .host_data_in(din),
    .host_data_out(dout), .host_data_oe_n(oe_n), .irq(irq),
    .chan_irq_req(req), .chan_irq_code(code), .chan_rdata(crd),
    .timer_timeout(tmo), .wake_event(wake), .chan_sel(sel),
    .chan_rd_pulse(rdp), .chan_wr_pulse(wrp), .chan_reg_addr(raddr),
    .chan_wdata(wd), .sampling_8x(s8x), .sleep_en(slp),
    .chan_soft_reset(srst), .timer_ctrl(tctl), .timer_count(tcnt));

  ougcb_host ougcb_host_inst (
    .clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .addr(addr), .wdata(din), .rdata(dout));

  // clock of 8 ns
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // capture the channel write strobe and any soft-reset bit seen
  always @(posedge clk)
  begin
    if (wrp)
    begin
      w_sel <= sel;
      w_addr <= raddr;
      w_data <= wd;
    end
    if (rdp)
      r_seen <= {sel, raddr};
    srst_seen <= reset ? 8'h00 : (srst_seen | srst);
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rc(input ougcb_byte_t a, input ougcb_byte_t exp);
    ougcb_testbench_rd(a);
    check(rv, exp);
  endtask : rc

  task automatic ougcb_testbench_rd(input ougcb_byte_t a);
    ougcb_host_inst.rd(a, rv);
  endtask : ougcb_testbench_rd

  // one-cycle pulse on an event input
  task automatic pulse(input logic sel_wake);
    @(negedge clk);
    if (sel_wake) wake = 1'b1;
    else tmo = 1'b1;
    @(negedge clk);
    wake = 1'b0;
    tmo = 1'b0;
    repeat (3) @(negedge clk);
  endtask : pulse

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    finish_test();
  end

  // main sequence
  initial
  begin
    {reset, tmo, wake, req, code} = {1'b1, 34'h0};
    crd = 64'h7766554433221100;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    check({s8x, slp, srst, tctl, tcnt}, 44'h0);
    for (int i = 0; i < 16; i++)
      rc(8'h80 + 8'(i), i == 12 ? REV : i == 13 ? DID : 8'h00);
    for (int i = 0; i < 8; i++)
      ougcb_host_inst.wr(wa[i], wv[i]);
    for (int i = 0; i < 8; i++)
      rc(wa[i], we[i]);
    check({tctl, tcnt, s8x, slp}, 36'hF_1234_03_A5);
    ougcb_host_inst.wr(8'h15, 8'h3C);
    check({w_sel, w_addr, w_data}, 20'hFF_5_3C);
    ougcb_host_inst.wr(8'h8E, 8'h00);
    ougcb_host_inst.wr(8'h23, 8'h5A);
    check({w_sel, w_addr, w_data}, 20'h04_3_5A);
    rc(8'h37, 8'h33);
    check(r_seen, 12'h087);
    ougcb_host_inst.wr(8'h8A, 8'h81);
    repeat (8) @(negedge clk);
    check({srst_seen, srst}, 16'h8100);
    rc(8'h8A, 8'h00);
    for (int c = 1; c < 5; c++)
    begin
      req = 8'hAD;
      code = {8{3'(c)}};
      repeat (3) @(negedge clk);
      rc(8'h80, 8'hAD);
      rc(8'h81, code[7:0]);
      rc(8'h82, code[15:8]);
      rc(8'h83, code[23:16]);
      check(irq, 1'b1);
    end
    {req, code} = 32'h0;
    repeat (3) @(negedge clk);
    rc(8'h80, 8'h00);
    pulse(1'b0);
    rc(8'h81, 8'h07);
    rc(8'h84, 8'h0F);
    rc(8'h81, 8'h00);
    ougcb_host_inst.wr(8'h84, 8'h00);
    pulse(1'b0);
    pulse(1'b1);
    check(irq, 1'b0);
    ougcb_host_inst.wr(8'h8B, 8'hFF);
    pulse(1'b1);
    check(irq, 1'b1);
    rc(8'h80, 8'h00);
    check({irq, oe_n}, 2'h1);
    finish_test();
  end

endmodule : testbench

`default_nettype wire
